// ===== verilog/rri_pkg.sv
// Package of register offsets, reset values and cause classes
package rri_pkg;
	// Register word offsets (byte addresses on the bus)
	localparam logic [7:0] OFS_PC_LOW      = 8'h00;
	localparam logic [7:0] OFS_STATUS      = 8'h04;
	localparam logic [7:0] OFS_PC_UPPER    = 8'h08;
	localparam logic [7:0] OFS_IRQ_CTRL    = 8'h0C;
	localparam logic [7:0] OFS_T1_CTRL     = 8'h10;
	localparam logic [7:0] OFS_T2_COUNT    = 8'h14;
	localparam logic [7:0] OFS_T2_CTRL     = 8'h18;
	localparam logic [7:0] OFS_SS_CTRL     = 8'h1C;
	localparam logic [7:0] OFS_CAP1_CTRL   = 8'h20;
	localparam logic [7:0] OFS_RX_CTRL     = 8'h24;
	localparam logic [7:0] OFS_TX_DATA     = 8'h28;
	localparam logic [7:0] OFS_RX_DATA     = 8'h2C;
	localparam logic [7:0] OFS_CAP2_CTRL   = 8'h30;
	localparam logic [7:0] OFS_CONV0       = 8'h34;
	localparam logic [7:0] OFS_PRESCALE    = 8'h38;
	localparam logic [7:0] OFS_DIR_A       = 8'h3C;
	localparam logic [7:0] OFS_DIR_B       = 8'h40;
	localparam logic [7:0] OFS_DIR_C       = 8'h44;
	localparam logic [7:0] OFS_DIR_D       = 8'h48;
	localparam logic [7:0] OFS_DIR_E       = 8'h4C;
	localparam logic [7:0] OFS_PWR         = 8'h50;
	localparam logic [7:0] OFS_T2_PERIOD   = 8'h54;
	localparam logic [7:0] OFS_SS_ADDR     = 8'h58;
	localparam logic [7:0] OFS_SS_STATE    = 8'h5C;
	localparam logic [7:0] OFS_TX_CTRL     = 8'h60;
	localparam logic [7:0] OFS_BAUD        = 8'h64;
	localparam logic [7:0] OFS_CONV1       = 8'h68;
	localparam logic [7:0] OFS_PORT_A      = 8'h6C;
	localparam logic [7:0] OFS_FLAGS1      = 8'h70;
	localparam logic [7:0] OFS_FLAGS2      = 8'h74;
	localparam logic [7:0] OFS_PC_HIGH     = 8'h78;
	localparam logic [7:0] OFS_CAUSE       = 8'h7C;
	// Reset values
	localparam logic [7:0] RST_ZERO8       = 8'h00;
	localparam logic [7:0] RST_ONES8       = 8'hFF;
	localparam logic [7:0] RST_STATUS_POR  = 8'h18;
	localparam logic [4:0] RST_PC_UPPER    = 5'h00;
	localparam logic [5:0] RST_DIR_A       = 6'h3F;
	localparam logic [7:0] RST_DIR_E       = 8'h07;
	localparam logic [7:0] RST_TX_CTRL     = 8'h02;
	localparam logic [12:0] RST_PC         = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
	// Implemented-bit masks (unimplemented bits read zero)
	localparam logic [7:0] MASK_DIR_E      = 8'hF7;
	localparam logic [7:0] MASK_TX_CTRL    = 8'hF7;
	localparam logic [7:0] MASK_RX_CTRL    = 8'hF7;
	localparam logic [7:0] MASK_CONV0      = 8'hFD;
	localparam logic [7:0] MASK_T2_CTRL    = 8'h7F;
	// Field positions
	localparam int STAT_TO_BIT  = 4;   // Time-out flag, active low
	localparam int STAT_PD_BIT  = 3;   // Power-down flag, active low
	localparam int PWR_POR_BIT  = 1;   // Power-on status, active low
	localparam int PWR_DIP_BIT  = 0;   // Supply-dip status, active low
	localparam int GIE_BIT      = 7;   // Global interrupt enable
	localparam int FIRST_IO_PORT_X_BIT  = 4;   // Port A bit left unknown
	// Reset-cause classes
	typedef enum logic [1:0] {
		CLS_NONE,
		CLS_POWER,
		CLS_PIN_WDT,
		CLS_WAKE
	} rri_class_type;
endpackage : rri_pkg

// ===== verilog/rri_core.sv
// Reset and wake-up initialisation of the special function registers

`timescale 1ns/1ns
module rri_core
	import rri_pkg::*;
(
	input  wire logic        ref_clk_in,     // Core clock, 20 MHz
	input  wire logic        rst_in,         // Synchronous reset, high
	input  wire logic        por_evt_in,     // Power-on reset pulse
	input  wire logic        dip_evt_in,     // Supply-dip reset pulse
	input  wire logic        pin_evt_in,     // External reset pin pulse
	input  wire logic        wdt_evt_in,     // Watchdog time-out pulse
	input  wire logic        asleep_in,      // Core is in sleep
	input  wire logic        irq_wake_in,    // Interrupt wake pulse
	input  wire logic [1:0]  wake_src_in,    // 0 irq ctl,1 flags1,2 flags2
	input  wire logic [2:0]  wake_bit_in,    // Bit index of wake source
	input  wire logic [12:0] pc_in,          // Current program counter
	input  wire logic [31:0] haddr,          // Bus address
	input  wire logic [1:0]  htrans,         // Bus transfer type
	input  wire logic        hwrite,         // Bus write
	input  wire logic [2:0]  hsize,          // Bus size
	input  wire logic [31:0] hwdata,         // Bus write data
	input  wire logic        hsel,           // Slave select
	input  wire logic        hready,         // Bus ready in
	output logic      [31:0] hrdata,         // Bus read data
	output logic             hreadyout,      // Slave ready
	output logic             hresp,          // Always OKAY
	output logic      [12:0] pc_load_out,    // Program counter load value
	output logic             pc_load_out_vld_out, // Load strobe
	output logic      [5:0]  port_a_dir_out  // First port directions
);
	////////////////////////////////////////////////////////////////////
	// Cause classification
	rri_class_type cls;
	logic          is_rst;
	logic          wake_irq_ff;

	// Encode the event into one class for this cycle
	always_comb begin
		cls = CLS_NONE;
		if (por_evt_in || dip_evt_in)
			cls = CLS_POWER;
		else if (pin_evt_in || (wdt_evt_in && !asleep_in))
			cls = CLS_PIN_WDT;
		else if (asleep_in && (wdt_evt_in || irq_wake_in))
			cls = CLS_WAKE;
	end
	assign is_rst = (cls == CLS_POWER) || (cls == CLS_PIN_WDT);

	////////////////////////////////////////////////////////////////////
	// Register storage
	// Program counter, status and power bits
	logic [7:0] pc_low_ff;
	logic [4:0] pc_high_ff;
	logic [4:0] pc_up_ff;
	logic [7:0] status_ff;
	logic [1:0] pwr_ff;

	// Interrupt control and peripheral flags
	logic [7:0] irq_ctl_ff;
	logic [5:0] flags1_ff;
	logic [7:0] flags2_ff;

	// Timer, serial, capture and converter controls
	logic [5:0] t1_ctl_ff;
	logic [7:0] t2_cnt_ff;
	logic [7:0] t2_ctl_ff;
	logic [7:0] t2_per_ff;
	logic [7:0] ss_ctl_ff;
	logic [7:0] ss_adr_ff;
	logic [7:0] ss_st_ff;
	logic [5:0] cap1_ff;
	logic [7:0] cap2_ff;
	logic [7:0] rx_ctl_ff;
	logic [7:0] rx_dat_ff;
	logic [7:0] tx_ctl_ff;
	logic [7:0] tx_dat_ff;
	logic [7:0] baud_ff;
	logic [7:0] conv0_ff;
	logic [2:0] conv1_ff;
	logic [7:0] presc_ff;

	// Port directions and first port output latch
	logic [5:0] dir_a_ff;
	logic [7:0] dir_b_ff;
	logic [7:0] dir_c_ff;
	logic [7:0] dir_d_ff;
	logic [7:0] dir_e_ff;
	logic [5:0] port_a_ff;

	// Last cause class, readable for diagnosis
	logic [1:0] last_cls_ff;

	// Bus pipeline
	logic       wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic       rd_en;
	logic       wr_hit;
	logic       addr_in_map;

	// Only the lowest 256 bytes decode; higher words would alias otherwise
	assign addr_in_map = (haddr[31:8] == 24'h00_0000);
	assign rd_en = hsel && hready && htrans[1] && !hwrite;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Address phase capture for writes
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= hsel && hready && htrans[1] && hwrite &&
				addr_in_map;
			wr_addr_ff <= haddr[7:0];
		end
	end
	assign wr_hit = wr_pend_ff;

	////////////////////////////////////////////////////////////////////
	// Program counter and status
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pc_low_ff  <= RST_ZERO8;
			pc_high_ff <= 5'h00;
			pc_up_ff   <= RST_PC_UPPER;
			status_ff  <= RST_STATUS_POR;
			pwr_ff     <= 2'b01;
		end else if (cls == CLS_POWER) begin
			pc_low_ff  <= RST_ZERO8;
			pc_high_ff <= 5'h00;
			pc_up_ff   <= RST_PC_UPPER;
			status_ff  <= RST_STATUS_POR;
			// Power-on clears its bit and sets bit0; a supply
			// dip clears bit0 only, the power-on bit keeps its value
			if (por_evt_in)
				pwr_ff[PWR_POR_BIT] <= 1'b0;
			pwr_ff[PWR_DIP_BIT] <= por_evt_in;
		end else if (cls == CLS_PIN_WDT) begin
			pc_low_ff  <= RST_ZERO8;
			pc_high_ff <= 5'h00;
			pc_up_ff   <= RST_PC_UPPER;
			status_ff[7:5] <= 3'b000;
			if (wdt_evt_in && !pin_evt_in) begin
				status_ff[STAT_TO_BIT] <= 1'b0;
				status_ff[STAT_PD_BIT] <= 1'b1;
			end else if (asleep_in) begin
				status_ff[STAT_TO_BIT] <= 1'b1;
				status_ff[STAT_PD_BIT] <= 1'b0;
			end
		end else if (cls == CLS_WAKE) begin
			// Resume at next instruction or the vector
			if (irq_wake_in && irq_ctl_ff[GIE_BIT])
				{pc_high_ff, pc_low_ff} <= IRQ_VECTOR;
			else
				{pc_high_ff, pc_low_ff} <= pc_in + 13'h0001;
			status_ff[STAT_TO_BIT] <= irq_wake_in && !wdt_evt_in;
			status_ff[STAT_PD_BIT] <= 1'b0;
		end else if (wr_hit) begin
			unique case (wr_addr_ff)
				OFS_PC_LOW:   pc_low_ff <= hwdata[7:0];
				OFS_PC_UPPER: pc_up_ff  <= hwdata[4:0];
				OFS_STATUS:   status_ff <= {hwdata[7:5], status_ff[4:3],
					hwdata[2:0]};
				OFS_PWR:      pwr_ff    <= hwdata[1:0];
				default:      ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt control and flag registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			irq_ctl_ff <= RST_ZERO8;
			flags1_ff  <= 6'h00;
			flags2_ff  <= RST_ZERO8;
		end else if (cls == CLS_POWER) begin
			irq_ctl_ff <= RST_ZERO8;
			flags1_ff  <= 6'h00;
			flags2_ff  <= RST_ZERO8;
		end else if (cls == CLS_PIN_WDT) begin
			irq_ctl_ff <= {7'h00, irq_ctl_ff[0]};
			flags1_ff  <= 6'h00;
			flags2_ff  <= RST_ZERO8;
		end else if (cls == CLS_WAKE) begin
			// Mark the source that caused the wake; a watchdog wake
			// marks the slot named on wake_src_in as well
			unique case (wake_src_in)
				2'd1:    flags1_ff[wake_bit_in] <= 1'b1;
				2'd2:    flags2_ff[wake_bit_in] <= 1'b1;
				default: irq_ctl_ff[wake_bit_in] <= 1'b1;
			endcase
		end else if (wr_hit) begin
			unique case (wr_addr_ff)
				OFS_IRQ_CTRL: irq_ctl_ff <= hwdata[7:0];
				OFS_FLAGS1:   flags1_ff  <= hwdata[5:0];
				OFS_FLAGS2:   flags2_ff  <= hwdata[7:0];
				default:      ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Peripheral control registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || cls == CLS_POWER) begin
			t1_ctl_ff <= 6'h00;
		end else if (wr_hit && !is_rst && cls != CLS_WAKE &&
			wr_addr_ff == OFS_T1_CTRL) begin
			t1_ctl_ff <= hwdata[5:0];
		end
	end

	// Registers reinitialised by every reset and kept on wake
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || is_rst) begin
			// Timer, serial, capture and converter controls
			t2_cnt_ff <= RST_ZERO8;
			t2_ctl_ff <= RST_ZERO8;
			ss_ctl_ff <= RST_ZERO8;
			cap1_ff   <= 6'h00;
			rx_ctl_ff <= RST_ZERO8;
			tx_dat_ff <= RST_ZERO8;
			rx_dat_ff <= RST_ZERO8;
			cap2_ff   <= RST_ZERO8;
			conv0_ff  <= RST_ZERO8;
			conv1_ff  <= 3'b000;
			// Prescaler, port directions (every pin an input), serial address, state, transmit control and baud
			presc_ff  <= RST_ONES8;
			dir_a_ff  <= RST_DIR_A;
			dir_b_ff  <= RST_ONES8;
			dir_c_ff  <= RST_ONES8;
			dir_d_ff  <= RST_ONES8;
			dir_e_ff  <= RST_DIR_E;
			ss_adr_ff <= RST_ZERO8;
			ss_st_ff  <= RST_ZERO8;
			tx_ctl_ff <= RST_TX_CTRL;
			baud_ff   <= RST_ZERO8;
		end else if (wr_hit && cls != CLS_WAKE) begin
			unique case (wr_addr_ff)
				OFS_T2_COUNT:  t2_cnt_ff <= hwdata[7:0];
				OFS_T2_CTRL:   t2_ctl_ff <= hwdata[7:0] & MASK_T2_CTRL;
				OFS_SS_CTRL:   ss_ctl_ff <= hwdata[7:0];
				OFS_CAP1_CTRL: cap1_ff   <= hwdata[5:0];
				OFS_RX_CTRL:   rx_ctl_ff <= hwdata[7:0] & MASK_RX_CTRL;
				OFS_TX_DATA:   tx_dat_ff <= hwdata[7:0];
				OFS_CAP2_CTRL: cap2_ff   <= hwdata[7:0];
				OFS_CONV0:     conv0_ff  <= hwdata[7:0] & MASK_CONV0;
				OFS_CONV1:     conv1_ff  <= hwdata[2:0];
				OFS_PRESCALE:  presc_ff  <= hwdata[7:0];
				OFS_DIR_A:     dir_a_ff  <= hwdata[5:0];
				OFS_DIR_B:     dir_b_ff  <= hwdata[7:0];
				OFS_DIR_C:     dir_c_ff  <= hwdata[7:0];
				OFS_DIR_D:     dir_d_ff  <= hwdata[7:0];
				OFS_DIR_E:     dir_e_ff  <= hwdata[7:0] & MASK_DIR_E;
				OFS_SS_ADDR:   ss_adr_ff <= hwdata[7:0];
				OFS_SS_STATE:  ss_st_ff  <= hwdata[7:0];
				OFS_TX_CTRL:   tx_ctl_ff <= hwdata[7:0] & MASK_TX_CTRL;
				OFS_BAUD:      baud_ff   <= hwdata[7:0];
				default:       ;
			endcase
		end
	end

	// First port output latch: one bit survives every reset, the
	// others return to zero; power-up of the block starts it at zero
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			port_a_ff <= 6'h00;
		end else if (is_rst) begin
			port_a_ff <= port_a_ff & (6'h01 << FIRST_IO_PORT_X_BIT);
		end else if (wr_hit && cls != CLS_WAKE &&
			wr_addr_ff == OFS_PORT_A) begin
			port_a_ff <= hwdata[5:0];
		end
	end

	// Timer2 period is all ones after resets and wake-ups alike
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || cls != CLS_NONE) begin
			t2_per_ff <= RST_ONES8;
		end else if (wr_hit && wr_addr_ff == OFS_T2_PERIOD) begin
			t2_per_ff <= hwdata[7:0];
		end
	end

	// Record the last cause class and the pc load strobe of any reset or wake-up
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			last_cls_ff <= 2'b00;
			wake_irq_ff <= 1'b0;
		end else begin
			if (cls != CLS_NONE)
				last_cls_ff <= cls;
			wake_irq_ff <= (cls != CLS_NONE);
		end
	end

	assign pc_load_out         = {pc_high_ff, pc_low_ff};
	assign pc_load_out_vld_out = wake_irq_ff;
	assign port_a_dir_out      = dir_a_ff;

	////////////////////////////////////////////////////////////////////
	// Read data, registered in the address phase
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_en && !addr_in_map) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (haddr[7:0])
				OFS_PC_LOW:    hrdata <= {24'h0, pc_low_ff};
				OFS_STATUS:    hrdata <= {24'h0, status_ff};
				OFS_PC_UPPER:  hrdata <= {27'h0, pc_up_ff};
				OFS_IRQ_CTRL:  hrdata <= {24'h0, irq_ctl_ff};
				OFS_T1_CTRL:   hrdata <= {26'h0, t1_ctl_ff};
				OFS_T2_COUNT:  hrdata <= {24'h0, t2_cnt_ff};
				OFS_T2_CTRL:   hrdata <= {24'h0, t2_ctl_ff};
				OFS_SS_CTRL:   hrdata <= {24'h0, ss_ctl_ff};
				OFS_CAP1_CTRL: hrdata <= {26'h0, cap1_ff};
				OFS_RX_CTRL:   hrdata <= {24'h0, rx_ctl_ff};
				OFS_RX_DATA:   hrdata <= {24'h0, rx_dat_ff};
				OFS_CAP2_CTRL: hrdata <= {24'h0, cap2_ff};
				OFS_CONV0:     hrdata <= {24'h0, conv0_ff};
				OFS_PRESCALE:  hrdata <= {24'h0, presc_ff};
				OFS_DIR_A:     hrdata <= {26'h0, dir_a_ff};
				OFS_DIR_B:     hrdata <= {24'h0, dir_b_ff};
				OFS_DIR_C:     hrdata <= {24'h0, dir_c_ff};
				OFS_DIR_D:     hrdata <= {24'h0, dir_d_ff};
				OFS_DIR_E:     hrdata <= {24'h0, dir_e_ff};
				OFS_PWR:       hrdata <= {30'h0, pwr_ff};
				OFS_T2_PERIOD: hrdata <= {24'h0, t2_per_ff};
				OFS_SS_ADDR:   hrdata <= {24'h0, ss_adr_ff};
				OFS_SS_STATE:  hrdata <= {24'h0, ss_st_ff};
				OFS_TX_CTRL:   hrdata <= {24'h0, tx_ctl_ff};
				OFS_BAUD:      hrdata <= {24'h0, baud_ff};
				OFS_CONV1:     hrdata <= {29'h0, conv1_ff};
				OFS_PORT_A:    hrdata <= {26'h0, port_a_ff};
				OFS_FLAGS1:    hrdata <= {26'h0, flags1_ff};
				OFS_FLAGS2:    hrdata <= {24'h0, flags2_ff};
				OFS_PC_HIGH:   hrdata <= {27'h0, pc_high_ff};
				OFS_CAUSE:     hrdata <= {30'h0, last_cls_ff};
				default:       hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : rri_core

// ===== testbench/rri_core_props.sv
// Checker of the reset and wake-up load behaviour at the core ports
`timescale 1ns/1ns
module rri_core_props
	import rri_pkg::*;
(
	input wire logic        ref_clk_in,          // Core clock
	input wire logic        rst_in,              // Synchronous reset
	input wire logic        por_evt_in,          // Power-on event
	input wire logic        dip_evt_in,          // Supply-dip event
	input wire logic        pin_evt_in,          // Reset pin event
	input wire logic        wdt_evt_in,          // Watchdog event
	input wire logic        asleep_in,           // Core asleep
	input wire logic        irq_wake_in,         // Interrupt wake
	input wire logic [12:0] pc_in,               // Current pc
	input wire logic        hreadyout,           // Slave ready
	input wire logic        hresp,               // Response
	input wire logic [12:0] pc_load_out,         // Pc load value
	input wire logic        pc_load_out_vld_out, // Load strobe
	input wire logic [5:0]  port_a_dir_out       // First port directions
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////////
	// Event classes as seen at the inputs
	logic any_rst;
	logic wdt_wake;
	logic irq_wake;
	assign any_rst  = por_evt_in | dip_evt_in | pin_evt_in |
		(wdt_evt_in & !asleep_in);
	assign wdt_wake = wdt_evt_in & asleep_in &
		!(por_evt_in | dip_evt_in | pin_evt_in);
	assign irq_wake = irq_wake_in & asleep_in & !(any_rst | wdt_evt_in);
	////////////////////////////////////////////////////////////////////////
	property p_bus_okay; hreadyout == 1'b1 && hresp == 1'b0; endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus not okay");
	property p_vld_evt; any_rst | wdt_wake | irq_wake |=> pc_load_out_vld_out; endproperty
	a_vld_evt: assert property (p_vld_evt) else $error("no strobe");
	property p_vld_cause;
		pc_load_out_vld_out && !$past(rst_in) |-> $past(any_rst | wdt_wake | irq_wake);
	endproperty
	a_vld_cause: assert property (p_vld_cause) else $error("stray strobe");
	property p_rst_pc; any_rst |=> pc_load_out == RST_PC; endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("pc not zero");
	property p_wdt_pc; wdt_wake |=> pc_load_out == $past(pc_in) + 13'h0001; endproperty
	a_wdt_pc: assert property (p_wdt_pc) else $error("wake pc");
	property p_irq_pc;
		irq_wake |=> pc_load_out == $past(pc_in) + 13'h0001 || pc_load_out == IRQ_VECTOR;
	endproperty
	a_irq_pc: assert property (p_irq_pc) else $error("irq wake pc");
	property p_dir_rst; any_rst |=> port_a_dir_out == RST_DIR_A; endproperty
	a_dir_rst: assert property (p_dir_rst) else $error("dir not input");
	property p_dir_init; $fell(rst_in) |-> port_a_dir_out == RST_DIR_A; endproperty
	a_dir_init: assert property (p_dir_init) else $error("dir init");
	property p_dir_wake; wdt_wake | irq_wake |=> $stable(port_a_dir_out); endproperty
	a_dir_wake: assert property (p_dir_wake) else $error("dir moved");
	property p_vld_one;
		pc_load_out_vld_out && !(any_rst | wdt_wake | irq_wake) |=> !pc_load_out_vld_out;
	endproperty
	a_vld_one: assert property (p_vld_one) else $error("strobe long");
	// Main scenarios
	c_irq: cover property (irq_wake ##1 pc_load_out == IRQ_VECTOR);
	c_wdt: cover property (wdt_wake ##1 pc_load_out_vld_out);
	c_por: cover property (por_evt_in ##1 pc_load_out_vld_out);
endmodule : rri_core_props
bind rri_core rri_core_props u_props (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
	.por_evt_in(por_evt_in), .dip_evt_in(dip_evt_in), .pin_evt_in(pin_evt_in),
	.wdt_evt_in(wdt_evt_in), .asleep_in(asleep_in), .irq_wake_in(irq_wake_in),
	.pc_in(pc_in), .hreadyout(hreadyout), .hresp(hresp), .pc_load_out(pc_load_out),
	.pc_load_out_vld_out(pc_load_out_vld_out), .port_a_dir_out(port_a_dir_out));

// ===== testbench/tb_top.sv
// Testbench of the reset and wake-up register initialisation
`timescale 1ns/1ns
module tb_top;
	import rri_pkg::*;
	logic        ref_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        por_evt_in = 1'b0, dip_evt_in = 1'b0, pin_evt_in = 1'b0;
	logic        wdt_evt_in = 1'b0, asleep_in = 1'b0, irq_wake_in = 1'b0;
	logic [1:0]  wake_src_in = 2'h0, htrans = 2'h0;
	logic [2:0]  wake_bit_in = 3'h0, hsize = 3'h2;
	logic [12:0] pc_in = 13'h0000, pc_load_out;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic        hwrite = 1'b0, hsel = 1'b0, hready, hreadyout, hresp;
	logic        pc_load_out_vld_out;
	logic [5:0]  port_a_dir_out;
	logic [7:0]  s;
	int          n_mismatch = 0, checks_done = 0;
	localparam logic [7:0] RA[10] = '{OFS_PC_LOW, OFS_STATUS, OFS_PWR,
		OFS_DIR_A, OFS_DIR_B, OFS_PRESCALE, OFS_T2_PERIOD, OFS_DIR_E,
		OFS_TX_CTRL, OFS_T2_COUNT};
	localparam logic [7:0] RV[10] = '{8'h00, 8'h18, 8'h01, 8'h3F, 8'hFF,
		8'hFF, 8'hFF, 8'h07, 8'h02, 8'h00};
	assign hready = hreadyout;
	always #25 ref_clk_in = ~ref_clk_in;
	rri_core dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.por_evt_in(por_evt_in), .dip_evt_in(dip_evt_in), .pin_evt_in(pin_evt_in),
		.wdt_evt_in(wdt_evt_in), .asleep_in(asleep_in), .irq_wake_in(irq_wake_in),
		.wake_src_in(wake_src_in), .wake_bit_in(wake_bit_in), .pc_in(pc_in),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pc_load_out(pc_load_out),
		.pc_load_out_vld_out(pc_load_out_vld_out), .port_a_dir_out(port_a_dir_out));
	////////////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// One single AHB transfer, waits for ready in both phases
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
		@(posedge ref_clk_in);
		while (hready !== 1'b1) @(posedge ref_clk_in);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		@(posedge ref_clk_in);
		while (hready !== 1'b1) @(posedge ref_clk_in);
		r = hrdata;
	endtask : bus
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask : wr
	task ck(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, {24'h0, e});
	endtask : ck
	// One-cycle cause pulse: 0 power, 1 dip, 2 pin, 3 watchdog, 4 irq wake
	task ev(input int k);
		por_evt_in <= k == 0; dip_evt_in <= k == 1; pin_evt_in <= k == 2;
		wdt_evt_in <= k == 3; irq_wake_in <= k == 4;
		@(posedge ref_clk_in);
		{por_evt_in, dip_evt_in, pin_evt_in, wdt_evt_in, irq_wake_in} <= 5'h00;
		@(posedge ref_clk_in);
		chk({31'h0, pc_load_out_vld_out}, 32'h1);
	endtask : ev
	task rs;
		bus(1'b0, OFS_STATUS, 32'h0);
		s = r[7:0];
	endtask : rs
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset;
		for (int i = 0; i < 10; i++) ck(RA[i], RV[i]);
		ck(OFS_RX_CTRL, 8'h00); ck(OFS_CONV0, 8'h00);
		ck(OFS_CONV1, 8'h00); ck(OFS_TX_CTRL, 8'h02);
		chk({26'h0, port_a_dir_out}, 32'h3F);
		wr(OFS_DIR_E, 8'hFF);
		ck(OFS_DIR_E, 8'hF7);
		wr(8'h80, 8'hFF);
		ck(8'h80, 8'h00);
		$display("reset values done");
	endtask : t_reset
	task t_pin;
		wr(OFS_T1_CTRL, 8'h3F); wr(OFS_T2_COUNT, 8'h55); wr(OFS_IRQ_CTRL, 8'hFF);
		wr(OFS_DIR_A, 8'h00); wr(OFS_PORT_A, 8'h3F); wr(OFS_PC_UPPER, 8'h1F);
		wr(OFS_RX_CTRL, 8'hFF); wr(OFS_CONV0, 8'hFF);
		ck(OFS_CONV0, 8'hFD);
		wr(OFS_STATUS, 8'hE7); rs; ev(2);
		chk({19'h0, pc_load_out}, 32'h0);
		ck(OFS_T1_CTRL, 8'h3F); ck(OFS_T2_COUNT, 8'h00);
		ck(OFS_IRQ_CTRL, 8'h01); ck(OFS_PORT_A, 8'h10);
		ck(OFS_STATUS, s & 8'h1F); ck(OFS_PWR, 8'h01);
		ck(OFS_DIR_E, 8'h07); ck(OFS_PC_UPPER, 8'h00);
		ck(OFS_RX_CTRL, 8'h00); ck(OFS_CONV0, 8'h00);
		chk({26'h0, port_a_dir_out}, 32'h3F);
		ck(OFS_CAUSE, 8'h02);
		wr(OFS_T2_COUNT, 8'h66); rs; ev(3);
		ck(OFS_STATUS, (s & 8'h07) | 8'h08); ck(OFS_T2_COUNT, 8'h00);
		ck(OFS_CAUSE, 8'h02);
		$display("pin and watchdog reset done");
	endtask : t_pin
	task t_wake;
		wr(OFS_T2_PERIOD, 8'h12); wr(OFS_T2_COUNT, 8'h34); wr(OFS_DIR_B, 8'h56);
		wr(OFS_PC_UPPER, 8'h0A); rs;
		asleep_in <= 1'b1; pc_in <= 13'h0123; wake_src_in <= 2'h1; wake_bit_in <= 3'h2;
		ev(3);
		chk({19'h0, pc_load_out}, 32'h124);
		ck(OFS_T2_PERIOD, 8'hFF); ck(OFS_T2_COUNT, 8'h34);
		ck(OFS_DIR_B, 8'h56); ck(OFS_PC_UPPER, 8'h0A);
		ck(OFS_STATUS, s & 8'hE7); ck(OFS_CAUSE, 8'h03);
		bus(1'b0, OFS_FLAGS1, 32'h0);
		chk(r & 32'h4, 32'h4);
		wr(OFS_IRQ_CTRL, 8'h80); rs;
		pc_in <= 13'h0200; wake_src_in <= 2'h0; wake_bit_in <= 3'h1;
		ev(4);
		chk({19'h0, pc_load_out}, 32'h4);
		ck(OFS_STATUS, (s & 8'hE7) | 8'h10);
		bus(1'b0, OFS_IRQ_CTRL, 32'h0);
		chk(r & 32'h82, 32'h82);
		wr(OFS_IRQ_CTRL, 8'h00);
		wake_src_in <= 2'h2; wake_bit_in <= 3'h5;
		ev(4);
		chk({19'h0, pc_load_out}, 32'h201);
		bus(1'b0, OFS_FLAGS2, 32'h0);
		chk(r & 32'h20, 32'h20);
		ev(3); rs; ev(2);
		ck(OFS_STATUS, (s & 8'h07) | 8'h10);
		asleep_in <= 1'b0;
		$display("wake-up done");
	endtask : t_wake
	task t_power;
		wr(OFS_T1_CTRL, 8'h3F); wr(OFS_PWR, 8'h03); rs; ev(1);
		ck(OFS_PWR, 8'h02); ck(OFS_T1_CTRL, 8'h00);
		ck(OFS_STATUS, 8'h18);
		wr(OFS_T1_CTRL, 8'h2A); ev(0);
		ck(OFS_PWR, 8'h01); ck(OFS_T1_CTRL, 8'h00);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(r & 32'hF8, 32'h18);
		ck(OFS_CAUSE, 8'h01);
		$display("power-up done");
	endtask : t_power
	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial begin
		repeat (16) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		t_reset; t_pin; t_wake; t_power;
		results;
	end
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		n_mismatch++;
		results;
	end
endmodule : tb_top
